// ### hdl/lbs_loopback_top.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module lbs_loopback_top
  import lbs_pkg::*;
#(
  parameter int NBYTE = 16
) (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Command-address pins
  input wire logic ckPin,
  input wire logic ckePin,
  input wire logic [CA_SIGS-2:0] caPins,
  input wire logic caParPin,
  // Data pins
  input wire logic wdqsPin,
  input wire logic [NBYTE*BUMPS-1:0] dqPins,
  input wire logic [NBYTE/4-1:0] dqParPins,
  // Protocol timing from the command path
  input wire logic wrDataValid,
  input wire logic readReq,
  // Control outputs
  output logic cmdDecodeEn,
  output logic ckeFunc,
  output logic dmIoEn,
  output logic dbiRxEn,
  output logic dbiTxEn,
  output logic caParErr,
  output logic [NBYTE/4-1:0] dataParErr,
  // Read return
  output logic [NBYTE*BYTE_SIGS-1:0] dqOut,
  output logic dqOe,
  output logic rdqs,
  output logic [NBYTE/4-1:0] parOut
);

  localparam int NDW = NBYTE / 4;
  localparam int DQ_OFS = 3 + CA_SIGS;
  localparam int PAR_OFS = DQ_OFS + NBYTE * BUMPS;
  localparam int SYNC_W = PAR_OFS + NDW;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_PRE = 2'b01,
    RD_BURST = 2'b11,
    RD_POST = 2'b10
  } lbs_rd_type;

  // Pin synchronisers
  logic [SYNC_W-1:0] pinVec, syncA_q, syncB_q;
  logic ckS, caParS, wdqsS;
  logic [CA_SIGS-1:0] caVec;
  logic [NBYTE*BUMPS-1:0] dqS;
  logic [NDW-1:0] dqParS;

  // Control registers
  logic caEn_q, caEn_d, loopEn_q, loopEn_d;
  lbs_mode_type caMode_q, caMode_d, dqMode_q, dqMode_d;
  logic [1:0] rdMux_q, rdMux_d;
  logic [4:0] base_q, base_d;
  logic [2:0] pl_q, pl_d;
  logic [3:0] byteSel_q, byteSel_d;
  logic [3:0] repIdx_q [NBYTE];
  logic [3:0] repIdx_d [NBYTE];
  logic dbiRem_q [NBYTE];
  logic dbiRem_d [NBYTE];
  logic [31:0] rdata_q, rdata_d;
  logic cmdDec_q, cmdDec_d, ckeF_q, ckeF_d, dmEn_q, dmEn_d;
  logic dbiRx_q, dbiRx_d, dbiTx_q, dbiTx_d;
  logic caPreset, dqPreset, seedWr, clrSticky;
  int selIdx;

  // Command-address signature state
  logic ckPrev_q, caArm_q, caArm_d, caPre_q, caPre_d;
  logic [CA_SIGS-1:0] caHold_q, caHold_d, caStk_q, caStk_d, caMiss;
  logic [CA_W-1:0] caSig_q, caSig_d, caDdr, caNxt;
  logic [CA_ERR_DLY-1:0] caPipe_q, caPipe_d;
  logic caRiseE, caFallE, caActive, caErr;

  // Data lane state
  logic wdqsPrev_q, dqRiseE, dqFallE, dqActive;
  logic [DQ_PIPE-1:0] dqPipe_q [NDW];
  logic [DQ_PIPE-1:0] dqPipe_d [NDW];
  logic [NDW-1:0] data_parity_error_out_q, data_parity_error_out_d, dqPar;
  logic [BYTE_SIGS-1:0] bLogic [NBYTE];
  logic [BYTE_W-1:0] bSig [NBYTE];
  logic [BYTE_W-1:0] bSmp [NBYTE];
  logic [BYTE_SIGS-1:0] bStk [NBYTE];

  // Read return state
  lbs_rd_type rdSt_q, rdSt_d;
  logic [3:0] rdCnt_q, rdCnt_d;
  logic [NBYTE*BYTE_SIGS-1:0] dqOut_q, dqOut_d;
  logic dqOe_q, dqOe_d, rdqs_q, rdqs_d, rdStep;
  logic [NDW-1:0] parOut_q, parOut_d;

  // Every pin is two flip-flops away from any logic
  assign pinVec = {dqParPins, dqPins, ckePin, caPins, wdqsPin, caParPin, ckPin};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else if (clkEn) begin
      syncA_q <= pinVec;
      syncB_q <= syncA_q;
    end
  end

  assign ckS = syncB_q[0];
  assign caParS = syncB_q[1];
  assign wdqsS = syncB_q[2];
  assign caVec = syncB_q[3 +: CA_SIGS];
  assign dqS = syncB_q[DQ_OFS +: NBYTE * BUMPS];
  assign dqParS = syncB_q[PAR_OFS +: NDW];
  // Out-of-range byte selects fall back to byte zero
  assign selIdx = (int'(byteSel_q) < NBYTE) ? int'(byteSel_q) : 0;

  // Register writes and their side effects
  always_comb begin
    caEn_d = caEn_q;
    caMode_d = caMode_q;
    loopEn_d = loopEn_q;
    dqMode_d = dqMode_q;
    rdMux_d = rdMux_q;
    base_d = base_q;
    pl_d = pl_q;
    byteSel_d = byteSel_q;
    repIdx_d = repIdx_q;
    dbiRem_d = dbiRem_q;
    caPreset = 1'b0;
    dqPreset = 1'b0;
    seedWr = regWr && regAddr == REG_DQ_SIG;
    clrSticky = regWr && regAddr == REG_STICKY;
    if (regWr) begin
      unique case (regAddr)
        REG_CA_CFG: begin
          caEn_d = regWdata[F_EN];
          caMode_d = lbs_mode_type'(regWdata[F_MODE +: 3]);
          caPreset = regWdata[F_EN] && regWdata[F_MODE +: 3] == M_PRESET;
        end
        REG_LOOP: begin
          loopEn_d = regWdata[F_EN];
          dqMode_d = lbs_mode_type'(regWdata[F_MODE +: 3]);
          rdMux_d = regWdata[F_MUX +: 2];
          dqPreset = regWdata[F_EN] && regWdata[F_MODE +: 3] == M_PRESET;
        end
        REG_BASE: base_d = regWdata[4:0];
        REG_PL: pl_d = regWdata[2:0];
        REG_BYTE_SEL: byteSel_d = regWdata[3:0];
        REG_REPAIR: begin
          repIdx_d[selIdx] = regWdata[3:0];
          dbiRem_d[selIdx] = regWdata[F_DBI_REM];
        end
        default: ;
      endcase
    end
    cmdDec_d = ~caEn_q;
    ckeF_d = caEn_q ? ckeF_q : caVec[CKE_IDX];
    dmEn_d = loopEn_q | base_q[F_ECC];
    dbiRx_d = base_q[F_WR_DBI];
    dbiTx_d = base_q[F_RD_DBI];
  end

  // Read data only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0;
    if (regRd) begin
      unique case (regAddr)
        REG_CA_CFG: rdata_d = {28'h0, caMode_q, caEn_q};
        REG_LOOP: rdata_d = {25'h0, rdMux_q, 1'b0, dqMode_q, loopEn_q};
        REG_BASE: rdata_d = {27'h0, base_q};
        REG_PL: rdata_d = {29'h0, pl_q};
        REG_BYTE_SEL: rdata_d = {28'h0, byteSel_q};
        REG_REPAIR: rdata_d = {27'h0, dbiRem_q[selIdx], repIdx_q[selIdx]};
        REG_CA_SIG: rdata_d = {2'h0, caSig_q};
        REG_DQ_SIG: rdata_d = {12'h0, bSig[selIdx]};
        REG_STICKY: rdata_d = {7'h0, caStk_q, bStk[selIdx]};
        REG_STATUS: rdata_d = {29'h0, rdSt_q != RD_IDLE, caPre_q, caArm_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      caEn_q <= 1'b0;
      caMode_q <= M_PRESET;
      loopEn_q <= 1'b0;
      dqMode_q <= M_PRESET;
      rdMux_q <= 2'h0;
      base_q <= 5'h00;
      pl_q <= PL_RST;
      byteSel_q <= 4'h0;
      for (int b = 0; b < NBYTE; b++) begin
        repIdx_q[b] <= REP_NONE;
        dbiRem_q[b] <= 1'b0;
      end
      rdata_q <= 32'h0;
      cmdDec_q <= 1'b1;
      ckeF_q <= 1'b0;
      dmEn_q <= 1'b0;
      dbiRx_q <= 1'b0;
      dbiTx_q <= 1'b0;
    end else if (clkEn) begin
      caEn_q <= caEn_d;
      caMode_q <= caMode_d;
      loopEn_q <= loopEn_d;
      dqMode_q <= dqMode_d;
      rdMux_q <= rdMux_d;
      base_q <= base_d;
      pl_q <= pl_d;
      byteSel_q <= byteSel_d;
      repIdx_q <= repIdx_d;
      dbiRem_q <= dbiRem_d;
      rdata_q <= rdata_d;
      cmdDec_q <= cmdDec_d;
      ckeF_q <= ckeF_d;
      dmEn_q <= dmEn_d;
      dbiRx_q <= dbiRx_d;
      dbiTx_q <= dbiTx_d;
    end
  end

  // Command-address capture on sampled clock edges
  always_comb begin
    caRiseE = ckS & ~ckPrev_q;
    caFallE = ~ckS & ckPrev_q;
    caActive = caEn_q && (caMode_q == M_REG || caMode_q == M_MISR || caMode_q == M_CMP);
    caNxt = lbsStep(caSig_q, CA_POLY, CA_W - 1);
    for (int i = 0; i < CA_SIGS; i++) begin
      caDdr[2 * i] = caHold_q[i];
      caDdr[2 * i + 1] = (i == CKE_IDX) ? caHold_q[i] : caVec[i];
      caMiss[i] = (caSig_q[2 * i] ^ caDdr[2 * i]) | (caSig_q[2 * i + 1] ^ caDdr[2 * i + 1]);
    end
    caMiss[CKE_IDX] = caSig_q[2 * CKE_IDX] ^ caHold_q[CKE_IDX];
    caArm_d = caArm_q;
    caPre_d = caPre_q;
    caHold_d = caHold_q;
    caSig_d = caSig_q;
    caStk_d = clrSticky ? '0 : caStk_q;
    caErr = 1'b0;
    if (caRiseE) begin
      if (caArm_q) begin
        caArm_d = 1'b0;
        caPre_d = 1'b1;
      end else begin
        caHold_d = caVec;
        caErr = caActive && base_q[F_CA_PAR] && (^{caVec[CA_SIGS-2:0], caParS});
      end
    end
    if (caFallE) begin
      if (caPre_q) begin
        caPre_d = 1'b0;
      end else if (caActive) begin
        unique case (caMode_q)
          M_REG: caSig_d = caDdr;
          M_MISR: caSig_d = caNxt ^ caDdr;
          M_CMP: begin
            caSig_d = caNxt;
            caStk_d = caStk_d | caMiss;
          end
          default: caSig_d = caSig_q;
        endcase
      end
    end
    if (caPreset) begin
      caSig_d = CA_PRESET;
      caArm_d = 1'b1;
      caPre_d = 1'b0;
    end
    caPipe_d = {caPipe_q[CA_ERR_DLY-2:0], caErr};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ckPrev_q <= 1'b0;
      caArm_q <= 1'b0;
      caPre_q <= 1'b0;
      caHold_q <= '0;
      caSig_q <= CA_PRESET;
      caStk_q <= '0;
      caPipe_q <= '0;
    end else if (clkEn) begin
      ckPrev_q <= ckS;
      caArm_q <= caArm_d;
      caPre_q <= caPre_d;
      caHold_q <= caHold_d;
      caSig_q <= caSig_d;
      caStk_q <= caStk_d;
      caPipe_q <= caPipe_d;
    end
  end

  // strobe edges count only inside the write data window
  assign dqRiseE = wdqsS & ~wdqsPrev_q & wrDataValid & loopEn_q;
  assign dqFallE = ~wdqsS & wdqsPrev_q & wrDataValid & loopEn_q;
  assign dqActive = dqMode_q == M_REG || dqMode_q == M_MISR || dqMode_q == M_CMP;

  // One signature register per byte
  for (genvar b = 0; b < NBYTE; b++) begin : gByte
    lbs_byte_misr uByte (
      .clk(sys_clk),
      .arstN(arst_n),
      .ce(clkEn),
      .active(loopEn_q),
      .mode(dqMode_q),
      .preset(dqPreset),
      .seedWr(seedWr && selIdx == b),
      .seedVal(regWdata[BYTE_W-1:0]),
      .clrSticky(clrSticky),
      .bumps(dqS[b * BUMPS +: BUMPS]),
      .repIdx(repIdx_q[b]),
      .dbiRemoved(dbiRem_q[b]),
      .riseStb(dqRiseE),
      .fallStb(dqFallE),
      .rdStep(rdStep),
      .logicBits(bLogic[b]),
      .sig(bSig[b]),
      .sample(bSmp[b]),
      .sticky(bStk[b])
    );
  end

  // Data parity per 32-bit group, delayed by the error delay plus latency
  always_comb begin
    for (int d = 0; d < NDW; d++) begin
      dqPar[d] = dqParS[d];
      for (int k = 0; k < 4; k++) begin
        for (int j = 0; j < 8; j++) begin
          dqPar[d] = dqPar[d] ^ bLogic[4 * d + k][j];
        end
      end
      dqPipe_d[d] = {dqPipe_q[d][DQ_PIPE-2:0],
                     dqRiseE && dqActive && base_q[F_DQ_PAR] && dqPar[d]};
      data_parity_error_out_d[d] = dqPipe_q[d][DQ_ERR_DLY - 2 + int'(pl_q)];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdqsPrev_q <= 1'b0;
      data_parity_error_out_q <= '0;
      for (int d = 0; d < NDW; d++) begin
        dqPipe_q[d] <= '0;
      end
    end else if (clkEn) begin
      wdqsPrev_q <= wdqsS;
      data_parity_error_out_q <= data_parity_error_out_d;
      dqPipe_q <= dqPipe_d;
    end
  end

  // Read return: preamble, burst of half cycles, postamble
  always_comb begin
    rdSt_d = rdSt_q;
    rdCnt_d = rdCnt_q + 4'h1;
    rdStep = 1'b0;
    unique case (rdSt_q)
      RD_IDLE: begin
        rdCnt_d = 4'h0;
        if (readReq && loopEn_q) begin
          rdSt_d = RD_PRE;
        end
      end
      RD_PRE: if (rdCnt_q == RD_PRE_CYC - 4'h1) begin
        rdSt_d = RD_BURST;
        rdCnt_d = 4'h0;
      end
      RD_BURST: begin
        rdStep = rdCnt_q[0] && dqMode_q == M_LFSR;
        if (rdCnt_q == BURST_HALVES - 4'h1) begin
          rdSt_d = RD_POST;
          rdCnt_d = 4'h0;
        end
      end
      RD_POST: if (rdCnt_q == RD_POST_CYC - 4'h1) begin
        rdSt_d = RD_IDLE;
      end
    endcase
    rdqs_d = (rdSt_q != RD_IDLE) ? ~rdqs_q : 1'b0;
    dqOe_d = rdSt_q == RD_BURST;
    for (int b = 0; b < NBYTE; b++) begin
      for (int i = 0; i < BYTE_SIGS; i++) begin
        if (rdMux_q == MUX_STICKY && dqMode_q != M_LFSR) begin
          dqOut_d[b * BYTE_SIGS + i] = bStk[b][i];
        end else if (rdMux_q == MUX_SAMPLER && dqMode_q != M_LFSR) begin
          dqOut_d[b * BYTE_SIGS + i] = bSmp[b][2 * i + int'(rdCnt_q[0])];
        end else begin
          dqOut_d[b * BYTE_SIGS + i] = bSig[b][2 * i + int'(rdCnt_q[0])];
        end
      end
    end
    if (!dqOe_d) begin
      dqOut_d = '0;
    end
    for (int d = 0; d < NDW; d++) begin
      parOut_d[d] = dqOe_d && dqMode_q == M_LFSR && dqOut_d[4 * d * BYTE_SIGS + DQ2_IDX];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdSt_q <= RD_IDLE;
      rdCnt_q <= 4'h0;
      dqOut_q <= '0;
      dqOe_q <= 1'b0;
      rdqs_q <= 1'b0;
      parOut_q <= '0;
    end else if (clkEn) begin
      rdSt_q <= rdSt_d;
      rdCnt_q <= rdCnt_d;
      dqOut_q <= dqOut_d;
      dqOe_q <= dqOe_d;
      rdqs_q <= rdqs_d;
      parOut_q <= parOut_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata = rdata_q;
  assign cmdDecodeEn = cmdDec_q;
  assign ckeFunc = ckeF_q;
  assign dmIoEn = dmEn_q;
  assign dbiRxEn = dbiRx_q;
  assign dbiTxEn = dbiTx_q;
  assign caParErr = caPipe_q[CA_ERR_DLY-1];
  assign dataParErr = data_parity_error_out_q;
  assign dqOut = dqOut_q;
  assign dqOe = dqOe_q;
  assign rdqs = rdqs_q;
  assign parOut = parOut_q;

endmodule

`default_nettype wire

// ### hdl/lbs_pkg.sv
package lbs_pkg;

  // Lane and signature geometry
  localparam int CA_SIGS = 15;
  localparam int CA_W = 30;
  localparam int CKE_IDX = 14;
  localparam int BYTE_SIGS = 10;
  localparam int BYTE_W = 20;
  localparam int BUMPS = 11;
  localparam int DBI_IDX = 8;
  localparam int DQ2_IDX = 2;
  localparam logic [3:0] REP_NONE = 4'ha;

  // Feedback taps below the top power, and preset states
  localparam logic [29:0] CA_POLY = 30'h0000_0053;
  localparam logic [29:0] CA_PRESET = 30'h2aaa_aaaa;
  localparam logic [29:0] DQ_POLY = 30'h0002_0001;
  localparam logic [19:0] DQ_PRESET = 20'haaaaa;

  // Signature mode codes
  typedef enum logic [2:0] {
    M_PRESET = 3'h0,
    M_LFSR = 3'h1,
    M_REG = 3'h2,
    M_MISR = 3'h3,
    M_CMP = 3'h5
  } lbs_mode_type;

  // Read return sources
  localparam logic [1:0] MUX_SAMPLER = 2'h2;
  localparam logic [1:0] MUX_STICKY = 2'h3;

  // Register indices
  localparam logic [3:0] REG_CA_CFG = 4'h0;
  localparam logic [3:0] REG_LOOP = 4'h1;
  localparam logic [3:0] REG_BASE = 4'h2;
  localparam logic [3:0] REG_PL = 4'h3;
  localparam logic [3:0] REG_BYTE_SEL = 4'h4;
  localparam logic [3:0] REG_REPAIR = 4'h5;
  localparam logic [3:0] REG_CA_SIG = 4'h6;
  localparam logic [3:0] REG_DQ_SIG = 4'h7;
  localparam logic [3:0] REG_STICKY = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;

  // Field positions
  localparam int F_EN = 0;
  localparam int F_MODE = 1;
  localparam int F_MUX = 5;
  localparam int F_WR_DBI = 0;
  localparam int F_RD_DBI = 1;
  localparam int F_CA_PAR = 2;
  localparam int F_DQ_PAR = 3;
  localparam int F_ECC = 4;
  localparam int F_DBI_REM = 4;

  // Reset values and cycle counts
  localparam logic [2:0] PL_RST = 3'h0;
  localparam int CA_ERR_DLY = 3;
  localparam int DQ_ERR_DLY = 3;
  localparam int DQ_PIPE = 16;
  localparam logic [3:0] RD_PRE_CYC = 4'h2;
  localparam logic [3:0] RD_POST_CYC = 4'h1;
  localparam logic [3:0] BURST_HALVES = 4'h4;

  // One Galois shift of a register whose top bit is msb
  function automatic logic [29:0] lbsStep(input logic [29:0] s, input logic [29:0] poly,
                                          input int msb);
    logic fb;
    logic [29:0] r;
    fb = s[msb];
    r = {s[28:0], 1'b0} ^ (fb ? poly : 30'h0);
    for (int i = 0; i < 30; i++) begin
      if (i > msb) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

endpackage

// ### hdl/lbs_byte_misr.sv
`timescale 1ns/100ps
`default_nettype none

module lbs_byte_misr
  import lbs_pkg::*;
(
  // Clock, reset, freeze
  input wire logic clk,
  input wire logic arstN,
  input wire logic ce,
  // Mode control
  input wire logic active,
  input wire lbs_mode_type mode,
  input wire logic preset,
  input wire logic seedWr,
  input wire logic [BYTE_W-1:0] seedVal,
  input wire logic clrSticky,
  // Synchronised lanes and strobes
  input wire logic [BUMPS-1:0] bumps,
  input wire logic [3:0] repIdx,
  input wire logic dbiRemoved,
  input wire logic riseStb,
  input wire logic fallStb,
  input wire logic rdStep,
  // Results
  output logic [BYTE_SIGS-1:0] logicBits,
  output logic [BYTE_W-1:0] sig,
  output logic [BYTE_W-1:0] sample,
  output logic [BYTE_SIGS-1:0] sticky
);

  logic [BYTE_SIGS-1:0] hold_q, hold_d, stk_q, stk_d, miss;
  logic [BYTE_W-1:0] sig_q, sig_d, smp_q, smp_d, ddr;
  logic [CA_W-1:0] nxt;

  // Bits follow logical signals: above a repaired lane each signal sits one bump up
  always_comb begin
    for (int i = 0; i < BYTE_SIGS; i++) begin
      logicBits[i] = (4'(i) >= repIdx) ? bumps[i + 1] : bumps[i];
    end
    if (dbiRemoved) begin
      logicBits[DBI_IDX] = 1'b0;
    end
  end

  // Next signature, sampler and sticky state
  always_comb begin
    hold_d = hold_q;
    sig_d = sig_q;
    smp_d = smp_q;
    nxt = lbsStep({10'h0, sig_q}, DQ_POLY, BYTE_W - 1);
    for (int i = 0; i < BYTE_SIGS; i++) begin
      ddr[2 * i] = hold_q[i];
      ddr[2 * i + 1] = logicBits[i];
      miss[i] = (sig_q[2 * i] ^ ddr[2 * i]) | (sig_q[2 * i + 1] ^ ddr[2 * i + 1]);
    end
    if (dbiRemoved) begin
      miss[DBI_IDX] = 1'b0;
    end
    if (riseStb) begin
      hold_d = logicBits;
    end
    // inversion and mask as raw data
    if (fallStb) begin
      smp_d = ddr;
      if (active) begin
        unique case (mode)
          M_REG: sig_d = ddr;
          M_MISR: sig_d = nxt[BYTE_W-1:0] ^ ddr;
          M_CMP: sig_d = nxt[BYTE_W-1:0];
          default: sig_d = sig_q;
        endcase
      end
    end
    if (rdStep && mode == M_LFSR) begin
      sig_d = nxt[BYTE_W-1:0];
    end
    if (seedWr) begin
      sig_d = seedVal;
    end
    if (preset) begin
      sig_d = DQ_PRESET;
    end
    // A miscompare in the clearing cycle still sets its bit
    stk_d = clrSticky ? '0 : stk_q;
    if (fallStb && active && mode == M_CMP) begin
      stk_d = stk_d | miss;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      hold_q <= '0;
      sig_q <= DQ_PRESET;
      smp_q <= '0;
      stk_q <= '0;
    end else if (ce) begin
      hold_q <= hold_d;
      sig_q <= sig_d;
      smp_q <= smp_d;
      stk_q <= stk_d;
    end
  end

  assign sig = sig_q;
  assign sample = smp_q;
  assign sticky = stk_q;

endmodule

`default_nettype wire

// ### dv/lbs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lbs_properties
  import lbs_pkg::*;
#(
  parameter int NBYTE = 16
) (
  // Clock, reset, register port
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  // Observed outputs
  input wire logic cmdDecodeEn,
  input wire logic ckeFunc,
  input wire logic dmIoEn,
  input wire logic dbiRxEn,
  input wire logic caParErr,
  input wire logic [NBYTE*BYTE_SIGS-1:0] dqOut,
  input wire logic dqOe,
  input wire logic rdqs,
  input wire logic [NBYTE/4-1:0] parOut
);
  logic [2:0] loopMode_q;
  logic [2:0] loopMode_d;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Shadow of the data-lane mode, only the parity copy check needs it
  always_comb begin
    loopMode_d = loopMode_q;
    if (regWr && clkEn && regAddr == REG_LOOP) loopMode_d = regWdata[3:1];
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) loopMode_q <= 3'h0;
    else loopMode_q <= loopMode_d;
  end
  decode_off_a: assert property (
    regWr && clkEn && regAddr == REG_CA_CFG && regWdata[0] |-> ##[1:2] !cmdDecodeEn)
    else $error("decode not disabled");
  cke_hold_a: assert property (!cmdDecodeEn [*2] |-> $stable(ckeFunc))
    else $error("clock enable moved");
  mask_buf_a: assert property (
    regWr && clkEn && regAddr == REG_LOOP && regWdata[0] |-> ##[1:2] dmIoEn)
    else $error("mask buffers off");
  dbi_source_a: assert property ($changed(dbiRxEn) |->
    $past(regWr && regAddr == REG_BASE) || $past(regWr && regAddr == REG_BASE, 2))
    else $error("inversion buffer moved");
  rd_preamble_a: assert property ($rose(dqOe) |-> !$past(rdqs) && $past(rdqs, 2))
    else $error("read preamble wrong");
  rd_burst_a: assert property ($rose(dqOe) |-> rdqs ##1 (dqOe && !rdqs)
    ##1 (dqOe && rdqs) ##1 (dqOe && !rdqs) ##1 (!dqOe && rdqs) ##1 !rdqs)
    else $error("read burst wrong");
  par_copy_a: assert property (
    dqOe && loopMode_q == M_LFSR |-> parOut[0] == dqOut[DQ2_IDX])
    else $error("parity copy wrong");
  ca_err_a: assert property (caParErr |-> !cmdDecodeEn)
    else $error("parity error outside mode");
endmodule
bind lbs_loopback_top lbs_properties #(.NBYTE(NBYTE)) i_lbs_properties (.sys_clk, .arst_n,
  .clkEn, .regAddr, .regWdata, .regWr, .cmdDecodeEn, .ckeFunc, .dmIoEn, .dbiRxEn,
  .caParErr, .dqOut, .dqOe, .rdqs, .parOut);
`default_nettype wire

// ### dv/lbs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lbs_host_model (
  // Frame request
  input wire logic go,
  input wire logic [3:0] nCyc,
  input wire logic [13:0] pat,
  input wire logic badPar,
  // Link pins
  output logic ckPin,
  output logic [13:0] caPins,
  output logic caParPin,
  output logic busy
);
  // Clock stands low between frames; released lanes show the inverse
  initial begin
    ckPin = 1'b0;
    busy = 1'b0;
    caPins = 14'h0;
    caParPin = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      caPins = pat;
      caParPin = ^pat ^ badPar;
      #400;
      repeat (nCyc) begin
        ckPin = 1'b1;
        #200;
        ckPin = 1'b0;
        #200;
      end
      #400;
      caPins = ~pat;
      caParPin = ~caParPin;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lbs_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic ckePin = 1'b0;
  logic readReq = 1'b0;
  logic go = 1'b0;
  logic badPar = 1'b0;
  logic [13:0] pat = 14'h0;
  logic [3:0] nCyc = 4'h1;
  logic clkEn = 1'b1;
  logic wdqsPin = 1'b0;
  logic wrDataValid = 1'b0;
  logic [175:0] dqPins = 176'h0;
  logic ckPin, caParPin, busy, cmdDecodeEn, ckeFunc, dmIoEn, dqOe, dbiTxEn, caParErr;
  logic [13:0] caPins;
  logic [31:0] regRdata;
  logic [159:0] dqOut;
  logic [3:0] dataParErr;
  int err_total = 0;
  int samples_checked = 0;
  int caErrs = 0;
  int dqErrs = 0;
  // Host side of the link and the design
  lbs_host_model i_lbs_host_model (.go(go), .nCyc(nCyc), .pat(pat), .badPar(badPar),
    .ckPin(ckPin), .caPins(caPins), .caParPin(caParPin), .busy(busy));
  lbs_loopback_top #(.NBYTE(16)) i_lbs_loopback_top (.sys_clk(sys_clk), .arst_n(arst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ckPin(ckPin), .ckePin(ckePin), .caPins(caPins),
    .caParPin(caParPin), .wdqsPin(wdqsPin), .dqPins(dqPins), .dqParPins(4'h0),
    .wrDataValid(wrDataValid), .readReq(readReq), .cmdDecodeEn(cmdDecodeEn),
    .ckeFunc(ckeFunc), .dmIoEn(dmIoEn), .dbiRxEn(), .dbiTxEn(dbiTxEn),
    .caParErr(caParErr), .dataParErr(dataParErr), .dqOut(dqOut), .dqOe(dqOe), .rdqs(),
    .parOut());
  always #25 sys_clk = ~sys_clk;
  // Error pulses last one cycle, so count them as they pass
  always @(posedge sys_clk) begin
    if (caParErr === 1'b1) caErrs++;
    if (dataParErr[0] === 1'b1) dqErrs++;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // One frame of nCyc link clock cycles; c drives the clock-enable pin and the host's bad parity
  task frame(input logic [13:0] p, input logic c);
    @(posedge sys_clk);
    {pat, ckePin, badPar, go} <= {p, c, c, 1'b1};
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge sys_clk);
    // A frame that never ends counts against the run
    if (busy !== 1'b0) err_total++;
    repeat (6) @(posedge sys_clk);
  endtask
  // Both clock-enable bits carry the rising sample
  function automatic logic [31:0] pairUp(input logic [13:0] p);
    logic [31:0] r;
    r = 32'h3000_0000;
    for (int i = 0; i < 14; i++) r[2*i +: 2] = {2{p[i]}};
    return r;
  endfunction
  task stop_test;
    $display("Compared %0d, mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    wr(REG_BASE, 32'hf);
    rd(4'hf, 32'h0);
    chk(cmdDecodeEn, 1'b1);
    chk(dbiTxEn, 1'b1);
    // A write while frozen must be lost
    clkEn <= 1'b0;
    wr(REG_BYTE_SEL, 32'h5);
    clkEn <= 1'b1;
    rd(REG_BYTE_SEL, 32'h0);
    wr(REG_CA_CFG, 32'h1);
    rd(REG_CA_SIG, {2'h0, CA_PRESET});
    wr(REG_CA_CFG, 32'h5);
    frame(14'h0, 1'b0);
    rd(REG_CA_SIG, {2'h0, CA_PRESET});
    nCyc <= 4'h2;
    frame(14'h2c35, 1'b1);
    rd(REG_CA_SIG, pairUp(14'h2c35));
    chk(ckeFunc, 1'b0);
    chk(cmdDecodeEn, 1'b0);
    chk(caErrs, 32'h2);
    wr(REG_CA_CFG, 32'h0);
    wr(REG_PL, 32'h1);
    rd(REG_PL, 32'h1);
    wr(REG_LOOP, 32'h5);
    // one strobe cycle inside the write data window
    {dqPins, wrDataValid} <= {176'h3fe, 1'b1};
    repeat (4) @(posedge sys_clk);
    wdqsPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wdqsPin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wrDataValid <= 1'b0;
    rd(REG_DQ_SIG, 32'hffffc);
    chk(dqErrs, 32'h1);
    chk(ckeFunc, 1'b1);
    wr(REG_LOOP, 32'h1);
    rd(REG_DQ_SIG, {12'h0, DQ_PRESET});
    chk(dmIoEn, 1'b1);
    wr(REG_LOOP, 32'h3);
    @(posedge sys_clk);
    readReq <= 1'b1;
    @(posedge sys_clk);
    readReq <= 1'b0;
    for (int i = 0; i < 20 && dqOe !== 1'b1; i++) @(posedge sys_clk) #1;
    chk(dqOe, 1'b1);
    chk(dqOut[9:0], 10'h0);
    @(posedge sys_clk) #1 chk(dqOut[9:0], 10'h3ff);
    stop_test;
  end
  // Watchdog far beyond the expected run
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
